// file: rtl/mie_defs.svh
// constants for the instruction execute subset: offsets, fields, reset values, timing
`ifndef MIE_DEFS_SVH
`define MIE_DEFS_SVH
`define MIE_DATA_W        8
`define MIE_PC_W          12
`define MIE_MEM_DEPTH     160
`define MIE_PCL_ADDR      8'h06
`define MIE_CLKS_PER_CYC  4
`define MIE_REG_CTRL      8'h00
`define MIE_REG_FLAGS     8'h04
`define MIE_REG_ACC       8'h08
`define MIE_REG_PC_LO     8'h0c
`define MIE_REG_PC_HI     8'h10
`define MIE_REG_WDT       8'h14
`define MIE_FLAG_Z        0
`define MIE_FLAG_C        1
`define MIE_FLAG_AC       2
`define MIE_FLAG_PDF      3
`define MIE_FLAG_TO       4
`define MIE_CTRL_GIE      0
`define MIE_CTRL_WDT_EN   1
`define MIE_RST_CTRL      8'h02
`define MIE_RST_BYTE      8'h00
`define MIE_RST_PC        12'h000
`endif

// file: rtl/mie_pkg.sv
// types shared by the instruction execute subset
package mie_pkg;
  typedef enum logic [4:0] {
    WATCHDOG_PRECLEAR_FIRST,
    WATCHDOG_PRECLEAR_SECOND,
    COMPLEMENT_MEMORY,
    COMPLEMENT_TO_WORKING_REG,
    DECIMAL_ADJUST,
    DECREMENT_MEMORY,
    DECREMENT_TO_WORKING_REG,
    INCREMENT_MEMORY,
    INCREMENT_TO_WORKING_REG,
    POWER_DOWN,
    DIRECT_JUMP,
    MOVE_IMM_TO_WORKING_REG,
    MOVE_MEM_TO_WORKING_REG,
    MOVE_WORKING_REG_TO_MEM,
    OR_MEM_TO_WORKING_REG,
    OR_IMM_TO_WORKING_REG,
    OR_INTO_MEMORY,
    RETURN_SUBROUTINE,
    RETURN_WITH_VALUE,
    RETURN_FROM_INTERRUPT,
    ROTATE_LEFT_MEMORY,
    ROTATE_LEFT_TO_WORKING_REG,
    NO_OPERATION
  } mie_op_e;

  typedef struct packed {
    mie_op_e      op;
    logic [7:0]   addr;
    logic [7:0]   imm;
    logic [11:0]  target;
  } mie_instr_s;

  typedef struct packed {
    logic [7:0]   addr;
    logic [31:0]  wdata;
    logic         we;
    logic         re;
  } mie_bus_req_s;
endpackage

// file: rtl/mie_core.sv
// execute stage for a subset of an 8-bit microcontroller instruction set
// Behaviour
// - both preclear instructions executed: watchdog counter zero, power-down and timeout flags cleared
// - only one preclear executed: record it, leave watchdog and both flags alone
// - complement memory inverts addressed byte, writes it back, updates zero only
// - complement to working register inverts byte into it, memory unchanged, zero only
// - low nibble above 9 or half carry: add 6, make nibble carry
// - high nibble plus nibble carry above 9 or carry: add 6, set carry
// - decrement subtracts one, zero flag only, memory or working register destination
// - increment adds one, zero flag only, memory or working register destination
// - power down stops execution and system clock, keeps memory and registers
// - power down clears watchdog and prescaler, sets power-down, clears timeout, pc plus one
// - direct jump loads pc from instruction, no flag changes
// - moves copy immediate or memory to working register, or back, no flags
// - or operations update zero only; or into memory writes memory
// - subroutine return reloads pc from stack, two cycles, no flags
// - return with value restores pc and loads immediate into working register
// - return from interrupt restores pc and sets global interrupt enable
// - left rotates move bit 7 into bit 0, no flags
// - no operation only advances pc
// - writing pc low byte adds one instruction cycle of four clocks
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "mie_defs.svh"
`default_nettype none
module mie_core
(
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  input  wire mie_pkg::mie_instr_s  instr_i,
  input  wire logic                 instr_valid_i,
  output logic                      instr_ready_o,
  input  wire logic [11:0]          stack_top_i,
  output logic                      stack_pop_o,
  input  wire logic                 wake_i,
  output logic                      sys_clk_en_o,
  output logic [11:0]               pc_o,
  output logic [7:0]                acc_o,
  input  wire mie_pkg::mie_bus_req_s bus_i,
  output logic [31:0]               rdata_o
);

  logic [7:0]   mem_q [0:`MIE_MEM_DEPTH-1];
  logic [7:0]   acc_q;
  logic [11:0]  pc_q;
  logic         z_q;
  logic         c_q;
  logic         ac_q;
  logic         pdf_q;
  logic         to_q;
  logic         gie_q;
  logic         wdt_en_q;
  logic         pre1_q;
  logic         pre2_q;
  logic [7:0]   wdt_q;
  logic [7:0]   presc_q;
  logic         halted_q;
  logic [3:0]   busy_q;
  logic         pop_q;
  logic [31:0]  rdata_q;
  logic         wake_s1_q;
  logic         wake_s2_q;

  logic         fire;
  logic [7:0]   m_val;
  logic [7:0]   res;
  logic         wr_mem;
  logic         wr_acc;
  logic         upd_z;
  logic         upd_c;
  logic         c_new;
  logic         jump;
  logic         ret;
  logic         two_cyc;
  logic         pcl_wr;
  logic         wdt_clr;
  logic         pre1_d;
  logic         pre2_d;
  logic [4:0]   lo_sum;
  logic         nib_c;
  logic [4:0]   hi_sum;
  logic [3:0]   hi_res;
  logic         wdt_ovf;
  logic         bus_wr_flags;
  logic         bus_wr_ctrl;

  // decoding shared by the register write path and the read path
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign fire          = instr_valid_i && instr_ready_o;
  assign instr_ready_o = (busy_q == 4'h0) && !halted_q;
  assign sys_clk_en_o  = !halted_q;
  assign stack_pop_o   = pop_q;
  assign pc_o          = pc_q;
  assign acc_o         = acc_q;
  assign rdata_o       = rdata_q;
  assign bus_wr_flags  = bus_i.we && hit(bus_i.addr, `MIE_REG_FLAGS);
  assign bus_wr_ctrl   = bus_i.we && hit(bus_i.addr, `MIE_REG_CTRL);

  // the pc low byte is mapped into data memory space
  always_comb
  begin
    if (instr_i.addr == `MIE_PCL_ADDR)
      m_val = pc_q[7:0];
    else if (instr_i.addr < `MIE_MEM_DEPTH)
      m_val = mem_q[instr_i.addr];
    else
      m_val = `MIE_RST_BYTE;
  end

  // decimal adjust nibble arithmetic
  always_comb
  begin
    lo_sum = {1'b0, acc_q[3:0]};
    nib_c  = 1'b0;
    if ((acc_q[3:0] > 4'h9) || ac_q)
    begin
      lo_sum = {1'b0, acc_q[3:0]} + 5'h06;
      nib_c  = lo_sum[4];
    end
    hi_sum = {1'b0, acc_q[7:4]} + {4'h0, nib_c};
    hi_res = hi_sum[3:0];
    c_new  = c_q;
    if ((hi_sum > 5'h09) || c_q)
    begin
      hi_res = hi_sum[3:0] + 4'h6;
      c_new  = 1'b1;
    end
  end

  always_comb
  begin
    res     = m_val;
    wr_mem  = 1'b0;
    wr_acc  = 1'b0;
    upd_z   = 1'b0;
    upd_c   = 1'b0;
    jump    = 1'b0;
    ret     = 1'b0;
    two_cyc = 1'b0;
    wdt_clr = 1'b0;
    pre1_d  = pre1_q;
    pre2_d  = pre2_q;
    case (instr_i.op)
      mie_pkg::WATCHDOG_PRECLEAR_FIRST:
      begin
        pre1_d = 1'b1;
        if (pre2_q)
        begin
          wdt_clr = 1'b1;
          pre1_d  = 1'b0;
          pre2_d  = 1'b0;
        end
      end
      mie_pkg::WATCHDOG_PRECLEAR_SECOND:
      begin
        pre2_d = 1'b1;
        if (pre1_q)
        begin
          wdt_clr = 1'b1;
          pre1_d  = 1'b0;
          pre2_d  = 1'b0;
        end
      end
      mie_pkg::COMPLEMENT_MEMORY:
      begin
        res    = ~m_val;
        wr_mem = 1'b1;
        upd_z  = 1'b1;
      end
      mie_pkg::COMPLEMENT_TO_WORKING_REG:
      begin
        res    = ~m_val;
        wr_acc = 1'b1;
        upd_z  = 1'b1;
      end
      mie_pkg::DECIMAL_ADJUST:
      begin
        res    = {hi_res, lo_sum[3:0]};
        wr_mem = 1'b1;
        upd_c  = 1'b1;
      end
      mie_pkg::DECREMENT_MEMORY:
      begin
        res    = m_val - 8'h01;
        wr_mem = 1'b1;
        upd_z  = 1'b1;
      end
      mie_pkg::DECREMENT_TO_WORKING_REG:
      begin
        res    = m_val - 8'h01;
        wr_acc = 1'b1;
        upd_z  = 1'b1;
      end
      mie_pkg::INCREMENT_MEMORY:
      begin
        res    = m_val + 8'h01;
        wr_mem = 1'b1;
        upd_z  = 1'b1;
      end
      mie_pkg::INCREMENT_TO_WORKING_REG:
      begin
        res    = m_val + 8'h01;
        wr_acc = 1'b1;
        upd_z  = 1'b1;
      end
      mie_pkg::POWER_DOWN:
        wdt_clr = 1'b1;
      mie_pkg::DIRECT_JUMP:
        jump = 1'b1;
      mie_pkg::MOVE_IMM_TO_WORKING_REG:
      begin
        res    = instr_i.imm;
        wr_acc = 1'b1;
      end
      mie_pkg::MOVE_MEM_TO_WORKING_REG:
        wr_acc = 1'b1;
      mie_pkg::MOVE_WORKING_REG_TO_MEM:
      begin
        res    = acc_q;
        wr_mem = 1'b1;
      end
      mie_pkg::OR_MEM_TO_WORKING_REG:
      begin
        res    = acc_q | m_val;
        wr_acc = 1'b1;
        upd_z  = 1'b1;
      end
      mie_pkg::OR_IMM_TO_WORKING_REG:
      begin
        res    = acc_q | instr_i.imm;
        wr_acc = 1'b1;
        upd_z  = 1'b1;
      end
      mie_pkg::OR_INTO_MEMORY:
      begin
        res    = acc_q | m_val;
        wr_mem = 1'b1;
        upd_z  = 1'b1;
      end
      mie_pkg::RETURN_SUBROUTINE:
      begin
        ret     = 1'b1;
        two_cyc = 1'b1;
      end
      mie_pkg::RETURN_WITH_VALUE:
      begin
        ret     = 1'b1;
        two_cyc = 1'b1;
        res     = instr_i.imm;
        wr_acc  = 1'b1;
      end
      mie_pkg::RETURN_FROM_INTERRUPT:
      begin
        ret     = 1'b1;
        two_cyc = 1'b1;
      end
      mie_pkg::ROTATE_LEFT_MEMORY:
      begin
        res    = {m_val[6:0], m_val[7]};
        wr_mem = 1'b1;
      end
      mie_pkg::ROTATE_LEFT_TO_WORKING_REG:
      begin
        res    = {m_val[6:0], m_val[7]};
        wr_acc = 1'b1;
      end
      default:
        res = m_val;
    endcase
  end

  assign pcl_wr  = wr_mem && (instr_i.addr == `MIE_PCL_ADDR);
  assign wdt_ovf = wdt_en_q && (presc_q == 8'hff) && (wdt_q == 8'hff);

  // instruction cycle pacing; a pc low byte write costs one extra cycle
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      busy_q <= 4'h0;
    else if (fire)
      busy_q <= 4'(`MIE_CLKS_PER_CYC * (1 + (two_cyc ? 1 : 0) + (pcl_wr ? 1 : 0)) - 1);
    else if (busy_q != 4'h0)
      busy_q <= busy_q - 4'h1;
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      pc_q <= `MIE_RST_PC;
    else if (fire && jump)
      pc_q <= instr_i.target;
    else if (fire && ret)
      pc_q <= stack_top_i;
    else if (fire && pcl_wr)
      pc_q <= {pc_q[11:8], res};
    else if (fire)
      pc_q <= pc_q + 12'h001;
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      pop_q <= 1'b0;
    else
      pop_q <= fire && ret;
  end

  always_ff @(posedge mclk_i)
  begin
    if (fire && wr_mem && !pcl_wr && (instr_i.addr < `MIE_MEM_DEPTH))
      mem_q[instr_i.addr] <= res;
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      acc_q <= `MIE_RST_BYTE;
    else if (fire && wr_acc)
      acc_q <= res;
    else if (bus_i.we && hit(bus_i.addr, `MIE_REG_ACC))
      acc_q <= bus_i.wdata[7:0];
  end

  // arithmetic flags; execution takes precedence over a software write
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      z_q  <= 1'b0;
      c_q  <= 1'b0;
      ac_q <= 1'b0;
    end
    else if (fire && (upd_z || upd_c))
    begin
      if (upd_z)
        z_q <= (res == 8'h00);
      if (upd_c)
        c_q <= c_new;
    end
    else if (bus_wr_flags)
    begin
      z_q  <= bus_i.wdata[`MIE_FLAG_Z];
      c_q  <= bus_i.wdata[`MIE_FLAG_C];
      ac_q <= bus_i.wdata[`MIE_FLAG_AC];
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pre1_q <= 1'b0;
      pre2_q <= 1'b0;
    end
    else if (fire)
    begin
      pre1_q <= pre1_d;
      pre2_q <= pre2_d;
    end
  end

  // watchdog: prescaler then counter; a timeout in the clearing cycle still lands
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      presc_q <= `MIE_RST_BYTE;
      wdt_q   <= `MIE_RST_BYTE;
    end
    else if (fire && wdt_clr)
    begin
      presc_q <= `MIE_RST_BYTE;
      wdt_q   <= `MIE_RST_BYTE;
    end
    else if (wdt_en_q)
    begin
      presc_q <= presc_q + 8'h01;
      if (presc_q == 8'hff)
        wdt_q <= wdt_q + 8'h01;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pdf_q <= 1'b0;
      to_q  <= 1'b0;
    end
    else
    begin
      if (fire && (instr_i.op == mie_pkg::POWER_DOWN))
        pdf_q <= 1'b1;
      else if (fire && wdt_clr)
        pdf_q <= 1'b0;
      if (wdt_ovf)
        to_q <= 1'b1;
      else if (fire && wdt_clr)
        to_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      gie_q    <= 1'(`MIE_RST_CTRL >> `MIE_CTRL_GIE);
      wdt_en_q <= 1'(`MIE_RST_CTRL >> `MIE_CTRL_WDT_EN);
    end
    else
    begin
      if (fire && (instr_i.op == mie_pkg::RETURN_FROM_INTERRUPT))
        gie_q <= 1'b1;
      else if (bus_wr_ctrl)
        gie_q <= bus_i.wdata[`MIE_CTRL_GIE];
      if (bus_wr_ctrl)
        wdt_en_q <= bus_i.wdata[`MIE_CTRL_WDT_EN];
    end
  end

  // wake arrives from a pin, so it is synchronised before use
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
    end
    else
    begin
      wake_s1_q <= wake_i;
      wake_s2_q <= wake_s1_q;
    end
  end

  // halted keeps memory and registers while the watchdog keeps counting; only wake or a watchdog timeout resumes
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      halted_q <= 1'b0;
    else if (fire && (instr_i.op == mie_pkg::POWER_DOWN))
      halted_q <= 1'b1;
    else if (wake_s2_q || wdt_ovf)
      halted_q <= 1'b0;
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_q <= 32'h0000_0000;
    else if (!bus_i.re)
      rdata_q <= 32'h0000_0000;
    else if (hit(bus_i.addr, `MIE_REG_CTRL))
      rdata_q <= {30'h0, wdt_en_q, gie_q};
    else if (hit(bus_i.addr, `MIE_REG_FLAGS))
      rdata_q <= {27'h0, to_q, pdf_q, ac_q, c_q, z_q};
    else if (hit(bus_i.addr, `MIE_REG_ACC))
      rdata_q <= {24'h0, acc_q};
    else if (hit(bus_i.addr, `MIE_REG_PC_LO))
      rdata_q <= {24'h0, pc_q[7:0]};
    else if (hit(bus_i.addr, `MIE_REG_PC_HI))
      rdata_q <= {28'h0, pc_q[11:8]};
    else if (hit(bus_i.addr, `MIE_REG_WDT))
      rdata_q <= {24'h0, wdt_q};
    else
      rdata_q <= 32'h0000_0000;
  end

endmodule
`default_nettype wire

// file: dv/mie_core_sva.sv
// port assertions for the execute subset
`timescale 1ns/1ps
`default_nettype none
module mie_core_sva
(
  input wire logic                mclk_i,
  input wire logic                rst_i,
  input wire mie_pkg::mie_instr_s instr_i,
  input wire logic                instr_valid_i,
  input wire logic                instr_ready_o,
  input wire logic [11:0]         stack_top_i,
  input wire logic                stack_pop_o,
  input wire logic                sys_clk_en_o,
  input wire logic [11:0]         pc_o,
  input wire logic [7:0]          acc_o
);
  logic        tk;
  logic        rt;
  logic [11:0] ret_q;
  assign tk = instr_valid_i && instr_ready_o;
  assign rt = tk && (instr_i.op inside {mie_pkg::RETURN_SUBROUTINE, mie_pkg::RETURN_WITH_VALUE,
                                        mie_pkg::RETURN_FROM_INTERRUPT});
  // return address is held so the pc check survives the pop
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      ret_q <= 12'h000;
    else if (rt)
      ret_q <= stack_top_i;
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  one_cycle_a: assert property (tk |=> !instr_ready_o [*3]) else $error("ready back early");
  ret_pop_a: assert property (rt |=> stack_pop_o) else $error("no pop after return");
  ret_busy_a: assert property (rt |=> !instr_ready_o [*7]) else $error("return too short");
  ret_pc_a: assert property (rt |-> ##[1:8] pc_o == ret_q) else $error("return pc wrong");
  jump_pc_a: assert property (tk && instr_i.op == mie_pkg::DIRECT_JUMP |=> pc_o == $past(instr_i.target))
    else $error("jump pc wrong");
  nop_pc_a: assert property (tk && instr_i.op == mie_pkg::NO_OPERATION |=> pc_o == $past(pc_o) + 12'h001
    && $stable(acc_o)) else $error("no-op wrong");
  halt_pc_a: assert property (tk && instr_i.op == mie_pkg::POWER_DOWN |=> !sys_clk_en_o
    && pc_o == $past(pc_o) + 12'h001) else $error("power-down wrong");
  halt_ready_a: assert property (!sys_clk_en_o |-> !instr_ready_o) else $error("ready while halted");
  value_acc_a: assert property (tk && instr_i.op == mie_pkg::RETURN_WITH_VALUE
    |=> acc_o == $past(instr_i.imm)) else $error("return value wrong");
  move_acc_a: assert property (tk && instr_i.op == mie_pkg::MOVE_IMM_TO_WORKING_REG
    |=> acc_o == $past(instr_i.imm)) else $error("move imm wrong");
  pcl_busy_a: assert property (tk && instr_i.op == mie_pkg::MOVE_WORKING_REG_TO_MEM && instr_i.addr == 8'h06
    |=> !instr_ready_o [*7]) else $error("pc low write too short");
endmodule
bind mie_core mie_core_sva i_sva (.mclk_i(mclk_i), .rst_i(rst_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
  .instr_ready_o(instr_ready_o), .stack_top_i(stack_top_i), .stack_pop_o(stack_pop_o),
  .sys_clk_en_o(sys_clk_en_o), .pc_o(pc_o), .acc_o(acc_o));
`default_nettype wire

// file: dv/mie_stack_model.sv
// return-address stack beside the execute stage
`timescale 1ns/1ps
`default_nettype none
module mie_stack_model
(
  input  wire logic   mclk_i,
  input  wire logic   rst_i,
  input  wire logic   pop_i,
  output logic [11:0] top_o
);
  logic [2:0] depth_q;
  // every pop exposes a new address, so a stale or missed pop shows as a wrong pc
  assign top_o = 12'h320 + {9'h000, depth_q};
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      depth_q <= 3'h0;
    else if (pop_i)
      depth_q <= depth_q + 3'h1;
  end
endmodule
`default_nettype wire

// file: dv/tb.sv
// self-checking bench for the execute subset
`timescale 1ns/1ps
`default_nettype none
`include "mie_defs.svh"
module tb;
  typedef struct packed {mie_pkg::mie_op_e op; logic [39:0] v; logic mem;} mie_row_s;
  logic                  mclk_i = 1'b0;
  logic                  rst_i = 1'b1;
  mie_pkg::mie_instr_s   instr = '0;
  logic                  valid = 1'b0;
  logic                  ready;
  logic [11:0]           stk;
  logic                  pop;
  logic                  wake = 1'b0;
  logic                  clk_en;
  logic [11:0]           pc;
  logic [7:0]            acc;
  mie_pkg::mie_bus_req_s bus = '0;
  logic [31:0]           rdata;
  logic [31:0]           r;
  int                    err_count = 0;
  int                    check_count = 0;
  int                    cyc = 0;
  int                    n;
  int                    pops = 0;
  mie_row_s              rows [19];
  always #5 mclk_i = ~mclk_i;
  mie_core i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .instr_i(instr), .instr_valid_i(valid), .instr_ready_o(ready),
    .stack_top_i(stk), .stack_pop_o(pop), .wake_i(wake), .sys_clk_en_o(clk_en), .pc_o(pc), .acc_o(acc),
    .bus_i(bus), .rdata_o(rdata));
  mie_stack_model i_stk (.mclk_i(mclk_i), .rst_i(rst_i), .pop_i(pop), .top_o(stk));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // n counts cycles with ready low after the accept, capped so a halt does not hang
  task automatic ex(input mie_pkg::mie_op_e op, input logic [7:0] ad, input logic [7:0] im, input logic [11:0] t);
    @(posedge mclk_i);
    instr <= '{op, ad, im, t};
    valid <= 1'b1;
    @(negedge mclk_i);
    for (int i = 0; i < 20 && ready !== 1'b1; i++) @(negedge mclk_i);
    @(posedge mclk_i);
    valid <= 1'b0;
    n = 0;
    @(negedge mclk_i);
    while (ready !== 1'b1 && n < 12)
    begin
      n++;
      @(negedge mclk_i);
    end
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge mclk_i);
    bus <= '{ad, 32'h0, 1'b0, 1'b1};
    @(posedge mclk_i);
    bus <= '0;
    @(negedge mclk_i);
    r = rdata;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge mclk_i);
    bus <= '{ad, {24'h0, d}, 1'b1, 1'b0};
    @(posedge mclk_i);
    bus <= '0;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      summarize();
    end
  end
  initial
  begin
    // v holds memory in, acc in, flags in, result, flags out
    rows = '{'{mie_pkg::COMPLEMENT_MEMORY, 40'hff00000001, 1'b1},
      '{mie_pkg::COMPLEMENT_TO_WORKING_REG, 40'h0f0001f000, 1'b0},
      '{mie_pkg::DECREMENT_MEMORY, 40'h0100060007, 1'b1},
      '{mie_pkg::DECREMENT_TO_WORKING_REG, 40'h000001ff00, 1'b0},
      '{mie_pkg::INCREMENT_MEMORY, 40'hff00000001, 1'b1},
      '{mie_pkg::INCREMENT_TO_WORKING_REG, 40'h7f00018000, 1'b0},
      '{mie_pkg::DECIMAL_ADJUST, 40'h009a000002, 1'b1},
      '{mie_pkg::DECIMAL_ADJUST, 40'h0045044b04, 1'b1},
      '{mie_pkg::DECIMAL_ADJUST, 40'h0012027202, 1'b1},
      '{mie_pkg::DECIMAL_ADJUST, 40'h000a001000, 1'b1},
      '{mie_pkg::MOVE_MEM_TO_WORKING_REG, 40'h0055000000, 1'b0},
      '{mie_pkg::MOVE_WORKING_REG_TO_MEM, 40'h1234073407, 1'b1},
      '{mie_pkg::OR_MEM_TO_WORKING_REG, 40'h0000000001, 1'b0},
      '{mie_pkg::OR_IMM_TO_WORKING_REG, 40'h8102018300, 1'b0},
      '{mie_pkg::OR_INTO_MEMORY, 40'hf00f01ff00, 1'b1},
      '{mie_pkg::ROTATE_LEFT_MEMORY, 40'h8100000300, 1'b1},
      '{mie_pkg::ROTATE_LEFT_TO_WORKING_REG, 40'h8000010101, 1'b0},
      '{mie_pkg::NO_OPERATION, 40'h1234053405, 1'b0},
      '{mie_pkg::RETURN_WITH_VALUE, 40'h5a00035a03, 1'b0}};
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(`MIE_REG_CTRL);
    chk("ctrl", 32'h02, r);
    rd(`MIE_REG_FLAGS);
    chk("flags", 32'h00, r);
    rd(8'h30);
    chk("unmapped", 32'h00, r);
    foreach (rows[i])
    begin
      ex(mie_pkg::MOVE_IMM_TO_WORKING_REG, 8'h00, rows[i].v[39:32], 12'h000);
      ex(mie_pkg::MOVE_WORKING_REG_TO_MEM, 8'h20, 8'h00, 12'h000);
      ex(mie_pkg::MOVE_IMM_TO_WORKING_REG, 8'h00, rows[i].v[31:24], 12'h000);
      wr(`MIE_REG_FLAGS, rows[i].v[23:16]);
      ex(rows[i].op, 8'h20, rows[i].v[39:32], 12'h000);
      chk("busy", rows[i].op == mie_pkg::RETURN_WITH_VALUE ? 32'h7 : 32'h3, n);
      rd(`MIE_REG_FLAGS);
      chk("zca", {24'h0, rows[i].v[7:0]}, r & 32'h7);
      rd(`MIE_REG_ACC);
      chk("acc", {24'h0, rows[i].mem ? rows[i].v[31:24] : rows[i].v[15:8]}, r);
      ex(mie_pkg::MOVE_MEM_TO_WORKING_REG, 8'h20, 8'h00, 12'h000);
      rd(`MIE_REG_ACC);
      chk("mem", {24'h0, rows[i].mem ? rows[i].v[15:8] : rows[i].v[39:32]}, r);
      if (rows[i].op == mie_pkg::RETURN_WITH_VALUE)
        pops++;
    end
    ex(mie_pkg::DIRECT_JUMP, 8'h00, 8'h00, 12'h5a3);
    chk("jump", 32'h5a3, {20'h0, pc});
    ex(mie_pkg::NO_OPERATION, 8'h00, 8'h00, 12'h000);
    chk("nop", 32'h5a4, {20'h0, pc});
    ex(mie_pkg::RETURN_SUBROUTINE, 8'h00, 8'h00, 12'h000);
    chk("ret busy", 32'h7, n);
    chk("ret pc", 32'h320 + pops, {20'h0, pc});
    pops++;
    wr(`MIE_REG_CTRL, 8'h02);
    ex(mie_pkg::RETURN_FROM_INTERRUPT, 8'h00, 8'h00, 12'h000);
    chk("return_from_interrupt pc", 32'h320 + pops, {20'h0, pc});
    rd(`MIE_REG_CTRL);
    chk("gie", 32'h03, r);
    ex(mie_pkg::MOVE_IMM_TO_WORKING_REG, 8'h00, 8'h40, 12'h000);
    ex(mie_pkg::MOVE_WORKING_REG_TO_MEM, `MIE_PCL_ADDR, 8'h00, 12'h000);
    chk("pcl busy", 32'h7, n);
    chk("pcl", 32'h40, {24'h0, pc[7:0]});
    ex(mie_pkg::MOVE_IMM_TO_WORKING_REG, 8'h00, 8'h77, 12'h000);
    ex(mie_pkg::POWER_DOWN, 8'h00, 8'h00, 12'h000);
    chk("halted", 32'hc, n);
    chk("clk en", 32'h0, {31'h0, clk_en});
    rd(`MIE_REG_FLAGS);
    chk("pdf to", 32'h08, r & 32'h18);
    rd(`MIE_REG_WDT);
    chk("wdt", 32'h0, r);
    @(posedge mclk_i);
    wake <= 1'b1;
    for (int i = 0; i < 10 && clk_en !== 1'b1; i++) @(posedge mclk_i);
    wake <= 1'b0;
    chk("wake", 32'h1, {31'h0, clk_en});
    chk("acc out", 32'h77, {24'h0, acc});
    rd(`MIE_REG_ACC);
    chk("kept acc", 32'h77, r);
    repeat (600) @(posedge mclk_i);
    ex(mie_pkg::WATCHDOG_PRECLEAR_FIRST, 8'h00, 8'h00, 12'h000);
    ex(mie_pkg::WATCHDOG_PRECLEAR_FIRST, 8'h00, 8'h00, 12'h000);
    rd(`MIE_REG_FLAGS);
    chk("half pdf", 32'h08, r & 32'h18);
    rd(`MIE_REG_WDT);
    chk("half wdt", 32'h1, {31'h0, r != 32'h0});
    ex(mie_pkg::WATCHDOG_PRECLEAR_SECOND, 8'h00, 8'h00, 12'h000);
    rd(`MIE_REG_FLAGS);
    chk("pair pdf", 32'h0, r & 32'h18);
    rd(`MIE_REG_WDT);
    chk("pair wdt", 32'h0, r);
    // reset in mid-run: state returns to its reset values and execution resumes from zero
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    chk("rst pc", 32'h0, {20'h0, pc});
    chk("rst acc", 32'h0, {24'h0, acc});
    chk("rst ready", 32'h1, {31'h0, ready});
    chk("rst clk en", 32'h1, {31'h0, clk_en});
    @(posedge mclk_i);
    rst_i <= 1'b0;
    ex(mie_pkg::NO_OPERATION, 8'h00, 8'h00, 12'h000);
    chk("nop after rst", 32'h1, {20'h0, pc});
    summarize();
  end
endmodule
`default_nettype wire
